// file: rtl/ccr_counter_ctrl.sv
/*
  Counter control block: control register, comparator-two control register
  and the sixteen-bit counter they steer, behind an Avalon-MM slave.
  Assumes a single 20 MHz clock; gate, comparator and count pins are
  asynchronous and are synchronised here, save the count pin in unsync mode (one capture flop). The crystal oscillator itself is
  external analog; this block only drives its enable.
*/
module ccr_counter_ctrl
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // External pins and comparator
  input  wire logic        gate_input_pin_i,
  input  wire logic        second_comparator_result_i,
  input  wire logic        ext_count_input_i,
  // Outputs
  output logic             low_power_osc_enable_o,
  output logic [15:0]      count_o
);
  // Registers
  logic [7:0]             ctrl_r;       // counter_control
  logic [7:0]             cmp2_r;       // comparator_two_control
  logic [15:0]            count_r;      // sixteen_bit_counter
  logic                   ack_r;        // Answer phase of a bus access
  logic [INSTR_CNT_W-1:0] instr_cnt_r;  // Instruction clock divider
  logic                   ext_prev_r;   // Previous sample of external input
  logic                   ext_raw_r;    // Single-stage capture for unsync path
  logic                   instr_tick_r; // One pulse per instruction cycle

  // Synchronised pins
  logic gate_pin_s;
  logic cmp_s;
  logic ext_s;

  // Combinational terms
  logic ext_sel;     // External level chosen by sync mode
  logic src_tick;    // Tick from chosen source
  logic pre_tick;    // Tick after prescaler
  logic gate_raw;    // Gate from chosen source
  logic gate_act;    // Gate after polarity
  logic count_ok;    // Counter may advance
  logic wr_acc;      // Write taken this cycle
  logic rd_acc;      // Read taken this cycle
  logic pre_clr;     // Restart prescaler

  // Byte-lane merge, used by both writable registers
  function automatic logic [7:0] merge8(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic be);
    merge8 = be ? new_v : old_v;
  endfunction

  // Synchronisers for every pin that reaches logic
  ccr_sync2 u_sync_gate (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .d_i    (gate_input_pin_i),
    .q_o    (gate_pin_s)
  );
  ccr_sync2 u_sync_cmp (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .d_i    (second_comparator_result_i),
    .q_o    (cmp_s)
  );
  ccr_sync2 u_sync_ext (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .d_i    (ext_count_input_i),
    .q_o    (ext_s)
  );

  // Bus access is taken in the answer cycle, one wait state per request
  assign wr_acc = avs_write_i && ack_r;
  assign rd_acc = avs_read_i && ack_r;

  // Answer phase toggles high for one cycle per request
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_i || avs_write_i) && !ack_r;
    end
  end

  // Waitrequest high except in the answer cycle, idle included
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_r);
    end
  end

  // Control register write
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_acc && avs_address_i == ADDR_CTRL) begin
      ctrl_r <= merge8(ctrl_r, avs_writedata_i[7:0], avs_byteenable_i[0]);
    end
  end

  // Comparator-two register: all eight bits are kept; only the gate source bit is used
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cmp2_r <= CMP2_RST;
    end else if (wr_acc && avs_address_i == ADDR_CMP2) begin
      cmp2_r <= merge8(cmp2_r, avs_writedata_i[7:0], avs_byteenable_i[0]);
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if ((avs_read_i || avs_write_i) && !ack_r) begin
      case (avs_address_i)
        ADDR_CTRL:  avs_readdata_o <= {24'h00_0000, ctrl_r};
        ADDR_CMP2:  avs_readdata_o <= {24'h00_0000, cmp2_r};
        ADDR_COUNT: avs_readdata_o <= {16'h0000, count_r};
        default:    avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Instruction clock: one pulse every four system clocks
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      instr_cnt_r  <= '0;
      instr_tick_r <= 1'b0;
    end else begin
      instr_cnt_r  <= instr_cnt_r + INSTR_CNT_W'(1);
      instr_tick_r <= (instr_cnt_r == INSTR_CNT_W'(INSTR_DIV - 1));
    end
  end

  // Unsynchronised path: one capture flop only, lower latency, metastable risk
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ext_raw_r <= 1'b0;
    end else begin
      ext_raw_r <= ext_count_input_i;
    end
  end

  // Unsync applies only with the external source selected
  assign ext_sel = (ctrl_r[F_SRC] && ctrl_r[F_UNSYNC]) ? ext_raw_r : ext_s;

  // Rising edge detect on the chosen external level
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_sel;
    end
  end

  // Source select: instruction clock or external rising edge
  assign src_tick = ctrl_r[F_SRC] ? (ext_sel && !ext_prev_r) : instr_tick_r;

  // Stopped counter also parks the prescaler
  assign pre_clr = !ctrl_r[F_RUN];

  ccr_prescaler u_pre (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .sel_i  (ctrl_r[F_DIV_HI:F_DIV_LO]),
    .clr_i  (pre_clr),
    .tick_i (src_tick),
    .tick_o (pre_tick)
  );

  // Gate source and polarity
  assign gate_raw = cmp2_r[F_GSRC] ? cmp_s : gate_pin_s;
  assign gate_act = ctrl_r[F_GATE_POL] ? gate_raw : !gate_raw;

  // Run and gate qualify the prescaled tick
  assign count_ok = ctrl_r[F_RUN] && (!ctrl_r[F_GATE_EN] || gate_act);

  // Counter advance
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      count_r <= COUNT_RST;
    end else if (pre_tick && count_ok) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // Registered outputs
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      low_power_osc_enable_o <= 1'b0;
      count_o                <= COUNT_RST;
    end else begin
      low_power_osc_enable_o <= ctrl_r[F_OSC];
      count_o                <= count_r;
    end
  end

  // Cycles since the last prescaled tick; saturates so a long quiet spell never wraps
  // Both counters below feed the divider check only and carry no behaviour
  logic [5:0] tick_gap_r;   // Cycles since the last prescaled tick
  logic [5:0] ctrl_age_r;   // Cycles since the control word was last written
  // A settled divide-by-eight stream sits eight instruction periods apart
  localparam logic [5:0] DIV8_GAP    = 6'(INSTR_DIV * 8 - 1);
  localparam logic [5:0] DIV8_SETTLE = 6'(INSTR_DIV * 8 + 8);

  // Gap counter restarts on every prescaled tick
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tick_gap_r <= 6'h3f;  // Reads as long ago
    end else if (pre_tick) begin
      tick_gap_r <= 6'h00;
    end else if (tick_gap_r != 6'h3f) begin
      tick_gap_r <= tick_gap_r + 6'h01;
    end
  end

  // Age counter restarts on every accepted control write, same value or not;
  // the check stays quiet until the prescaler has run one full period since
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctrl_age_r <= 6'h00;
    end else if (wr_acc && avs_address_i == ADDR_CTRL) begin
      ctrl_age_r <= 6'h00;
    end else if (ctrl_age_r != 6'h3f) begin
      ctrl_age_r <= ctrl_age_r + 6'h01;
    end
  end

  // Reset clears the whole control register
  a_ctrl_reset: assert property (@(posedge mclk_i)
    $fell(srst_i) |-> ctrl_r == CTRL_RST) else $error("control not zero after reset");
  // A fresh request sees exactly one wait state
  a_bus_answer: assert property (@(posedge mclk_i) disable iff (srst_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
  // Accepted control write lands in full
  a_ctrl_write: assert property (@(posedge mclk_i) disable iff (srst_i)
    avs_write_i && !avs_waitrequest_o && avs_address_i == ADDR_CTRL && avs_byteenable_i[0]
    |=> ctrl_r == $past(avs_writedata_i[7:0])) else $error("control write lost");
  // Control read returns the register with zero upper bits
  a_ctrl_read: assert property (@(posedge mclk_i) disable iff (srst_i)
    rd_acc && avs_address_i == ADDR_CTRL |-> avs_readdata_o == {24'h00_0000, ctrl_r})
    else $error("control read wrong");
  // Gated off: no advance
  a_gate_blocks: assert property (@(posedge mclk_i) disable iff (srst_i)
    ctrl_r[F_RUN] && ctrl_r[F_GATE_EN] && !gate_act |=> $stable(count_r))
    else $error("counter moved while gate inactive");
  // Ungated running: every prescaled tick counts
  a_free_count: assert property (@(posedge mclk_i) disable iff (srst_i)
    pre_tick && ctrl_r[F_RUN] && !ctrl_r[F_GATE_EN] |=> count_r == $past(count_r) + 16'h0001)
    else $error("ungated tick lost");
  // Comparator source at its counting level: each prescaled tick lands
  a_gate_source: assert property (@(posedge mclk_i) disable iff (srst_i)
    pre_tick && ctrl_r[F_RUN] && ctrl_r[F_GATE_EN] && cmp2_r[F_GSRC]
    && cmp_s == ctrl_r[F_GATE_POL] |=> count_r == $past(count_r) + 16'h0001)
    else $error("comparator gate lost a tick");
  // Internal source ticks exactly once in four clocks
  a_instr_rate: assert property (@(posedge mclk_i) disable iff (srst_i)
    instr_tick_r |=> !instr_tick_r [*3] ##1 instr_tick_r)
    else $error("instruction tick rate wrong");
  // Synchronised mode never uses the raw capture
  a_sync_path: assert property (@(posedge mclk_i) disable iff (srst_i)
    !ctrl_r[F_SRC] || !ctrl_r[F_UNSYNC] |-> ext_sel == ext_s)
    else $error("unsync used in wrong mode");
  // Oscillator enable follows the field one cycle later
  a_osc_follow: assert property (@(posedge mclk_i) disable iff (srst_i)
    ##1 low_power_osc_enable_o == $past(ctrl_r[F_OSC])) else $error("osc enable lag");
  // Pin source at the level opposite the polarity bit: no advance
  a_gate_polar: assert property (@(posedge mclk_i) disable iff (srst_i)
    ctrl_r[F_RUN] && ctrl_r[F_GATE_EN] && !cmp2_r[F_GSRC]
    && gate_pin_s != ctrl_r[F_GATE_POL] |=> $stable(count_r))
    else $error("pin gate polarity wrong");
  // Stopped counter holds its value
  a_run_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    !ctrl_r[F_RUN] |=> $stable(count_r)) else $error("stopped counter moved");
  // Settled 1:8 prescale on the internal source: ticks exactly eight instruction
  // periods apart; a write restarts the settling so a divider change never trips it
  a_div_eight: assert property (@(posedge mclk_i) disable iff (srst_i)
    pre_tick && ctrl_r[F_DIV_HI:F_DIV_LO] == 2'b11 && !ctrl_r[F_SRC] && ctrl_r[F_RUN]
    && ctrl_age_r >= DIV8_SETTLE |-> tick_gap_r == DIV8_GAP)
    else $error("divide by eight rate wrong");
endmodule // ccr_counter_ctrl

// file: rtl/ccr_pkg.sv
/*
  Package for the counter control block: register map, field positions,
  reset values and timing constants.
  Assumes a single 20 MHz system clock and a 32-bit Avalon-MM slave port.
*/
package ccr_pkg;
  // Clock rate and derived instruction clock divide
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned INSTR_DIV      = 4;          // Instruction clock is osc/4
  localparam int unsigned INSTR_CNT_W    = 2;
  // Register byte addresses
  localparam logic [3:0]  ADDR_CTRL      = 4'h0;       // counter_control
  localparam logic [3:0]  ADDR_CMP2      = 4'h4;       // comparator_two_control
  localparam logic [3:0]  ADDR_COUNT     = 4'h8;       // sixteen_bit_counter value
  // counter_control field positions
  localparam int unsigned F_RUN          = 0;
  localparam int unsigned F_SRC          = 1;
  localparam int unsigned F_UNSYNC       = 2;
  localparam int unsigned F_OSC          = 3;
  localparam int unsigned F_DIV_LO       = 4;
  localparam int unsigned F_DIV_HI       = 5;
  localparam int unsigned F_GATE_EN      = 6;
  localparam int unsigned F_GATE_POL     = 7;
  // comparator_two_control field positions
  localparam int unsigned F_GSRC         = 1;
  // Reset values
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  localparam logic [7:0]  CMP2_RST       = 8'h02;
  localparam logic [15:0] COUNT_RST      = 16'h0000;
  // Divider widths
  localparam int unsigned PRE_W          = 3;
endpackage : ccr_pkg

// file: rtl/ccr_sync2.sv
/*
  Two flip-flop synchroniser for one level signal.
  Assumes the input is asynchronous to mclk_i; only stage two is read outside.
*/
module ccr_sync2 (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic srst_i,
  // Level in and out
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;  // First stage, read only by second stage

  // Both stages on every edge; reset to a constant
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule // ccr_sync2

// file: rtl/ccr_prescaler.sv
/*
  Input prescaler: passes one of every 1, 2, 4 or 8 input ticks.
  Assumes tick_i is a one-cycle pulse on mclk_i; clr_i restarts the count.
*/
module ccr_prescaler
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  // Control
  input  wire logic [1:0] sel_i,
  input  wire logic       clr_i,
  // Ticks
  input  wire logic       tick_i,
  output logic            tick_o
);
  logic [PRE_W-1:0] cnt_r;  // Prescale count
  logic [PRE_W-1:0] mask;   // Terminal count for the chosen ratio

  // Ratio 2^sel: terminal count is 0,1,3,7
  always_comb begin
    mask = PRE_W'((4'd1 << sel_i) - 4'd1);
  end

  // Count ticks, emit a pulse on terminal count
  always_ff @(posedge mclk_i) begin
    if (srst_i || clr_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else if (tick_i) begin
      if (cnt_r >= mask) begin
        cnt_r  <= '0;
        tick_o <= 1'b1;
      end else begin
        cnt_r  <= cnt_r + PRE_W'(1);
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end

  // Back-to-back pulses: a second output pulse only after an input tick in the first cycle
  a_pre_single: assert property (@(posedge mclk_i) disable iff (srst_i)
    tick_o |=> !tick_o || $past(tick_i)) else $error("prescaler pulse without input");
endmodule // ccr_prescaler

// file: bench/test_counter_control_register.sv
/*
  Self-checking bench for the counter control block: register access,
  run/stop, count source, prescale, gate and oscillator enable.
  Assumes ccr_pkg and ccr_counter_ctrl are compiled before this file.
*/
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("Error at %0t ns: %s", $time, msg); end end
module test_counter_control_register
  import ccr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Design stimulus and observation
  logic        mclk_i;
  logic        srst_i;
  logic [3:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        gate_input_pin_i;
  logic        second_comparator_result_i;
  logic        ext_count_input_i;
  logic        low_power_osc_enable_o;
  logic [15:0] count_o;
  // Bench state
  int          errors;
  int          check_count;
  int          seed;
  logic [31:0] rd;
  logic [7:0]  v;

  ccr_counter_ctrl dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .gate_input_pin_i(gate_input_pin_i),
    .second_comparator_result_i(second_comparator_result_i),
    .ext_count_input_i(ext_count_input_i),
    .low_power_osc_enable_o(low_power_osc_enable_o), .count_o(count_o));

  // 20 MHz system clock
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // Verdict in one place, reached by the main sequence or a spent wait
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One Avalon access; held until waitrequest is sampled low, bounded wait
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] r);
    int n;
    n = 0;
    avs_address_i    <= a;
    avs_writedata_i  <= wd;
    avs_byteenable_i <= be;
    avs_write_i      <= wr;
    avs_read_i       <= ~wr;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    r = avs_readdata_o;
    if (avs_waitrequest_o !== 1'b0) begin
      errors++;
      $display("Error at %0t ns: bus wait spent", $time);
      wrap_up();
    end
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    // Idle edge so the next request never re-drives in this time step
    @(posedge mclk_i);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h00_0000, d}, 4'hf, rd);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0000_0000, 4'hf, rd);
    `CHK(rd, e, m)
  endtask

  // Expected increments over a window: one per 4 mclk, then the divider
  function automatic int exp_cnt(input int cyc, input int p);
    return cyc / (4 << p);
  endfunction

  // Count advance over cyc cycles must sit in lo..hi
  task automatic rate(input int cyc, input int lo, input int hi, input string m);
    logic [15:0] c0;
    logic [15:0] d;
    repeat (8) @(posedge mclk_i);
    c0 = count_o;
    repeat (cyc) @(posedge mclk_i);
    d = count_o - c0;
    `CHK((d >= lo && d <= hi), 1'b1, m)
  endtask

  // n rising edges on the external input, random spacing; n/div expected
  task automatic ext_run(input int n, input int lo, input int hi, input string m);
    logic [15:0] c0;
    logic [15:0] d;
    int          h;
    repeat (8) @(posedge mclk_i);
    c0 = count_o;
    repeat (n) begin
      h = 3 + ($unsigned($random(seed)) % 4);
      ext_count_input_i <= 1'b1;
      repeat (h) @(posedge mclk_i);
      ext_count_input_i <= 1'b0;
      repeat (h) @(posedge mclk_i);
    end
    repeat (8) @(posedge mclk_i);
    d = count_o - c0;
    `CHK((d >= lo && d <= hi), 1'b1, m)
  endtask

  initial begin
    seed = 32'hd5d2;
    errors = 0;
    check_count = 0;
    srst_i = 1'b1;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'h0;
    gate_input_pin_i = 1'b0;
    second_comparator_result_i = 1'b0;
    ext_count_input_i = 1'b0;
    repeat (16) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    // Reset values, then held count while stopped
    rd_chk(ADDR_CTRL, 32'h0000_0000, "control reset");
    rd_chk(ADDR_CMP2, {24'h00_0000, CMP2_RST}, "cmp2 reset");
    `CHK(low_power_osc_enable_o, 1'b0, "osc reset")
    rate(64, 0, 0, "stopped counter moved");
    $display("reset test done");
    // Random write and readback; oscillator enable follows its bit
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      wr_reg(ADDR_CTRL, v);
      rd_chk(ADDR_CTRL, {24'h00_0000, v}, "control readback");
      `CHK(low_power_osc_enable_o, v[F_OSC], "osc enable")
    end
    // Write with lane 0 off is ignored; unmapped word reads zero
    bus(1'b1, ADDR_CTRL, ~{24'h00_0000, v}, 4'he, rd);
    rd_chk(ADDR_CTRL, {24'h00_0000, v}, "lane 0 off");
    rd_chk(4'hc, 32'h0000_0000, "unmapped read");
    $display("register test done");
    // Internal source, every divider code, gate off; sync-off bit ignored
    wr_reg(ADDR_CTRL, 8'h00);
    rate(64, 0, 0, "run clear");
    for (int p = 0; p < 4; p++) begin
      wr_reg(ADDR_CTRL, {2'b00, 2'(p), 4'b0001});
      rate(32 * (4 << p), exp_cnt(32 * (4 << p), p) - 1, exp_cnt(32 * (4 << p), p) + 1,
           "divider rate");
    end
    wr_reg(ADDR_CTRL, 8'h05);
    rate(32, 7, 9, "sync-off on internal");
    $display("prescale test done");
    // Gate from comparator (reset choice), then from the pin
    wr_reg(ADDR_CTRL, 8'h41);
    rate(32, 7, 9, "gate low counts");
    second_comparator_result_i <= 1'b1;
    gate_input_pin_i <= 1'($random(seed));
    rate(64, 0, 0, "gate high blocks");
    wr_reg(ADDR_CTRL, 8'hc1);
    rate(32, 7, 9, "inverted gate counts");
    wr_reg(ADDR_CMP2, 8'h00);
    gate_input_pin_i <= 1'b0;
    rate(64, 0, 0, "pin gate blocks");
    gate_input_pin_i <= 1'b1;
    rate(32, 7, 9, "pin gate counts");
    gate_input_pin_i <= 1'b0;
    wr_reg(ADDR_CTRL, 8'h01);
    rate(32, 7, 9, "gate disabled counts");
    wr_reg(ADDR_CTRL, 8'h40);
    gate_input_pin_i <= 1'b1;
    rate(64, 0, 0, "gate while stopped");
    // Stopped count reads back over the bus and ignores a write
    rd_chk(ADDR_COUNT, {16'h0000, count_o}, "count readback");
    bus(1'b1, ADDR_COUNT, 32'h0000_ffff, 4'hf, rd);
    rd_chk(ADDR_COUNT, {16'h0000, count_o}, "count read-only");
    $display("gate test done");
    // External input: synced, unsynced, divided by 4
    wr_reg(ADDR_CTRL, 8'h03);
    ext_run(8, 8, 8, "external synced");
    wr_reg(ADDR_CTRL, 8'h07);
    ext_run(8, 8, 8, "external unsynced");
    wr_reg(ADDR_CTRL, 8'h23);
    ext_run(8, 1, 3, "external divided");
    $display("external test done");
    // Second reset mid-run, oscillator and run set: all fields and the count clear
    wr_reg(ADDR_CTRL, 8'h0b);
    srst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    `CHK(count_o, 16'h0000, "count after reset")
    `CHK(low_power_osc_enable_o, 1'b0, "osc after reset")
    rd_chk(ADDR_CTRL, 32'h0000_0000, "control after reset");
    $display("second reset test done");
    wrap_up();
  end
endmodule // test_counter_control_register
